//--- dv/ahb_master.sv
`timescale 1ns/1ps
// ******
// Bus master
// ******
module ahb_master (
	input  logic        hclk,
	input  logic        hready,
	input  logic [31:0] hrdata,
	output logic [31:0] haddr = 32'h0,
	output logic [1:0]  htrans = 2'h0,
	output logic        hwrite = 1'b0,
	output logic [31:0] hwdata = 32'h0
);
	task automatic hold();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) test_encoder_extended_diagnostics.timeout();
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hold();
		htrans <= 2'h0;
		hwdata <= wd;
		hold();
		rd = hrdata;
	endtask
endmodule // ahb_master

//--- dv/encdiag_sva.sv
`timescale 1ns/1ps
// ******
// Checker
// ******
module encdiag_sva (
	input logic        hclk,
	input logic        hresetn,
	input logic        ce,
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic [31:0] hrdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] scan_pos,
	input logic        int_err_pin,
	input logic [31:0] pos_out,
	input logic        pos_valid,
	input logic        ext_diag,
	input logic        stat_diag
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_take;
	assign rd_take = ce && hsel && hready && htrans[1] && !hwrite;
	warn_sup_a: assert property (rd_take && haddr == 32'h8 |=> hrdata == 32'h1f)
		else $error("bad warn support");
	version_word_a: assert property (rd_take && haddr == 32'hc |=> hrdata == 32'h01400100)
		else $error("bad version");
	maker_area_a: assert property (rd_take && haddr == 32'h34 |=> hrdata == 32'h0)
		else $error("maker area set");
	bus_answer_a: assert property (hreadyout && !hresp)
		else $error("bus answer not okay");
	flags_pair_a: assert property (ext_diag == stat_diag)
		else $error("flags differ");
	flag_rise_a: assert property ($rose(stat_diag) |-> $past(int_err_pin, 3))
		else $error("flag without error");
	flag_fall_a: assert property ($fell(stat_diag) |-> !$past(int_err_pin, 3))
		else $error("flag cleared early");
	pos_hold_a: assert property (stat_diag ##1 stat_diag |-> !pos_valid && $stable(pos_out))
		else $error("position not held");
	pos_pass_a: assert property (ce && !stat_diag ##1 !stat_diag |-> pos_out == $past(scan_pos))
		else $error("position wrong");
endmodule // encdiag_sva

bind encoder_extended_diagnostics encdiag_sva encdiag_sva_inst (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scan_pos(scan_pos),
	.int_err_pin(int_err_pin), .pos_out(pos_out), .pos_valid(pos_valid), .ext_diag(ext_diag),
	.stat_diag(stat_diag));

//--- dv/test_encoder_extended_diagnostics.sv
`timescale 1ns/1ps
// ******
// Bench
// ******
module test_encoder_extended_diagnostics;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr, hwdata, hrdata, pos_out;
	logic [31:0] scan_pos = 32'h0, mfr_ofs_in = 32'h0;
	logic [4:0]  warn_pin = 5'h0;
	logic [1:0]  htrans;
	logic        hwrite, hreadyout, hresp, int_err_pin = 1'b0;
	logic        pos_valid, ext_diag, stat_diag, irq;
	int          mismatches = 0, total_checks = 0;
	always #4 hclk = ~hclk;
	ahb_master ahb_master_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
	encoder_extended_diagnostics #(.OPH_TICK_CYC(36'd20)) encoder_extended_diagnostics_inst (
		.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .warn_pin(warn_pin),
		.int_err_pin(int_err_pin), .scan_pos(scan_pos), .mfr_ofs_in(mfr_ofs_in),
		.pos_out(pos_out), .pos_valid(pos_valid), .ext_diag(ext_diag),
		.stat_diag(stat_diag), .irq(irq));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		ahb_master_inst.xfer(1'b0, a, 32'h0, d);
		chk(d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb_master_inst.xfer(1'b1, a, d, x);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic timeout();
		mismatches++;
		report_and_stop();
	endtask
	task automatic t_reset();
		rc(8'h00, 32'h3);
		rc(8'h20, 32'h2000);
		rc(8'h24, 32'h02000000);
		rc(8'h08, 32'h1f);
		rc(8'h0c, 32'h01400100);
		rc(8'h34, 32'h0);
		rc(8'h3c, 32'h0);
	endtask
	task automatic t_cfg();
		wr(8'h20, 32'h10000);
		rc(8'h20, 32'h10000);
		wr(8'h24, 32'habc0000);
		rc(8'h24, 32'habc0000);
		wr(8'h0c, 32'h0);
		rc(8'h0c, 32'h01400100);
	endtask
	task automatic t_preset();
		logic [31:0] d;
		chk(32'(irq), 32'h0);
		wr(8'h30, 32'h4);
		scan_pos <= 32'h1234;
		mfr_ofs_in <= 32'h550000;
		wr(8'h14, 32'h2000);
		rc(8'h18, 32'hdcc);
		rc(8'h1c, 32'h550000);
		chk(32'(irq), 32'h1);
		ahb_master_inst.xfer(1'b0, 8'h2c, 32'h0, d);
		chk(d & 32'h4, 32'h4);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h0);
	endtask
	task automatic t_oph();
		logic [31:0] a, b;
		ahb_master_inst.xfer(1'b0, 8'h10, 32'h0, a);
		repeat (198) @(posedge hclk);
		ahb_master_inst.xfer(1'b0, 8'h10, 32'h0, b);
		chk(b - a, 32'd10);
		wr(8'h00, 32'h1);
		rc(8'h10, 32'h00ffffff);
		wr(8'h00, 32'h3);
	endtask
	task automatic t_warn();
		logic [31:0] d;
		wr(8'h30, 32'h2);
		warn_pin <= 5'h15;
		repeat (4) @(posedge hclk);
		rc(8'h04, 32'h15);
		chk(32'(irq), 32'h1);
		ahb_master_inst.xfer(1'b0, 8'h2c, 32'h0, d);
		chk(d & 32'h2, 32'h2);
		repeat (2) @(posedge hclk);
		chk(32'(irq), 32'h0);
		warn_pin <= 5'h0;
	endtask
	task automatic t_err();
		wr(8'h30, 32'h1);
		int_err_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		chk(32'({ext_diag, stat_diag, pos_valid}), 32'h6);
		chk(32'(irq), 32'h1);
		wr(8'h28, 32'h0);
		wr(8'h2c, 32'hf);
		chk(32'(stat_diag), 32'h1);
		int_err_pin <= 1'b0;
		repeat (6) @(posedge hclk);
		chk(32'({ext_diag, stat_diag, pos_valid}), 32'h1);
		wr(8'h00, 32'h2);
		int_err_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		chk(32'({stat_diag, pos_valid}), 32'h1);
		int_err_pin <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_cfg();
		t_preset();
		t_oph();
		t_warn();
		t_err();
		report_and_stop();
	end
endmodule // test_encoder_extended_diagnostics

//--- rtl/encoder_extended_diagnostics.sv
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module encoder_extended_diagnostics #(
	parameter logic [35:0] OPH_TICK_CYC = encdiag_pkg::OPH_TICK_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [4:0]  warn_pin,
	input  wire logic        int_err_pin,
	input  wire logic [31:0] scan_pos,
	input  wire logic [31:0] mfr_ofs_in,
	output logic [31:0]      pos_out,
	output logic             pos_valid,
	output logic             ext_diag,
	output logic             stat_diag,
	output logic             irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [5:0]  sync1;
		logic [5:0]  sync2;
		logic [4:0]  warn_prev;
		logic [1:0]  ctrl;
		logic [31:0] preset;
		logic [31:0] offset;
		logic [31:0] mfr_ofs;
		logic [31:0] res;
		logic [31:0] mlen;
		logic        ext_diag;
		logic        stat_diag;
		logic [3:0]  irq_st;
		logic [3:0]  irq_mask;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
		logic        irq;
		logic [31:0] pos;
		logic        pos_valid;
	} state_t;

	state_t q, d;

	logic [31:0] oph_count;
	logic        oph_tick;

	// ****************************************
	// Operating hour counter
	// ****************************************
	ophour_counter #(
		.TICK_CYC (OPH_TICK_CYC)
	) u_oph (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.run     (q.ctrl[encdiag_pkg::CTRL_OPH_EN]),
		.count   (oph_count),
		.tick    (oph_tick)
	);

	// ****************************************
	// Read decode
	// ****************************************
	function automatic logic in_map(input logic [31:0] addr);
		return addr[31:8] == 24'h0;
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a, input state_t s,
			input logic [31:0] oph);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			encdiag_pkg::OFS_CTRL:     r = {30'h0, s.ctrl};
			encdiag_pkg::OFS_WARN:     r = {27'h0, s.sync2[4:0]};
			encdiag_pkg::OFS_WARN_SUP: r = {16'h0, encdiag_pkg::WARN_SUP};
			encdiag_pkg::OFS_VERSION:
				r = {encdiag_pkg::PROF_REV_NUM, encdiag_pkg::PROF_REV_IDX,
					encdiag_pkg::FW_REV_NUM, encdiag_pkg::FW_REV_IDX};
			encdiag_pkg::OFS_OPHOURS:
				r = s.ctrl[encdiag_pkg::CTRL_OPH_EN] ? oph : encdiag_pkg::OPH_MAX;
			encdiag_pkg::OFS_PRESET:   r = s.preset;
			encdiag_pkg::OFS_OFFSET:   r = s.offset;
			encdiag_pkg::OFS_MFR_OFS:  r = s.mfr_ofs;
			encdiag_pkg::OFS_RES:      r = s.res;
			encdiag_pkg::OFS_MLEN:     r = s.mlen;
			encdiag_pkg::OFS_DIAG:     r = {30'h0, s.stat_diag, s.ext_diag};
			encdiag_pkg::OFS_IRQ_ST:   r = {28'h0, s.irq_st};
			encdiag_pkg::OFS_IRQ_MASK: r = {28'h0, s.irq_mask};
			encdiag_pkg::OFS_MFR_AREA: r = 32'h0;
			default:                   r = 32'h0;
		endcase
		return r;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic       addr_ph;
		logic       err_now;
		logic       diag_en;
		logic [3:0] ev;
		logic [7:0] a;
		addr_ph = 1'b0;
		err_now = 1'b0;
		diag_en = 1'b0;
		ev = 4'h0;
		a = 8'h0;
		d = q;

		// Pin synchronisers
		d.sync1 = {int_err_pin, warn_pin};
		d.sync2 = q.sync1;
		d.warn_prev = q.sync2[4:0];
		if (|(q.sync2[4:0] & ~q.warn_prev)) begin
			ev[encdiag_pkg::EV_WARN] = 1'b1;
		end

		// Data phase of a write
		d.wr_pend = 1'b0;
		if (q.wr_pend) begin
			case (q.wr_addr)
				encdiag_pkg::OFS_CTRL: begin
					d.ctrl = hwdata[1:0];
				end
				encdiag_pkg::OFS_PRESET: begin
					d.preset = hwdata;
					d.offset = hwdata - scan_pos;
					d.mfr_ofs = mfr_ofs_in;
					ev[encdiag_pkg::EV_PRESET] = 1'b1;
				end
				encdiag_pkg::OFS_RES: begin
					d.res = hwdata;
				end
				encdiag_pkg::OFS_MLEN: begin
					d.mlen = hwdata;
				end
				encdiag_pkg::OFS_IRQ_MASK: begin
					d.irq_mask = hwdata[3:0];
				end
				default: begin
					d.ctrl = d.ctrl;
				end
			endcase
		end

		// Error flags, bus writes have no path to them
		err_now = q.sync2[5];
		diag_en = q.ctrl[encdiag_pkg::CTRL_DIAG_EN];
		if (err_now && diag_en) begin
			d.ext_diag = 1'b1;
			d.stat_diag = 1'b1;
		end else if (!err_now) begin
			d.ext_diag = 1'b0;
			d.stat_diag = 1'b0;
		end
		if (d.stat_diag && !q.stat_diag) begin
			ev[encdiag_pkg::EV_ERROR] = 1'b1;
		end
		ev[encdiag_pkg::EV_OPH_TICK] = oph_tick;

		// Position output held back during error
		if (q.stat_diag) begin
			d.pos_valid = 1'b0;
			d.pos = q.pos;
		end else begin
			d.pos_valid = 1'b1;
			d.pos = scan_pos;
		end

		// Address phase
		addr_ph = hsel && hready && htrans[1];
		a = {haddr[7:2], 2'b00};
		d.hreadyout = 1'b1;
		d.hresp = 1'b0;
		if (addr_ph && hwrite && in_map(haddr)) begin
			d.wr_pend = 1'b1;
			d.wr_addr = a;
		end
		if (addr_ph && !hwrite) begin
			d.hrdata = in_map(haddr) ? rd_word(a, d, oph_count) : 32'h0;
		end

		// Sticky interrupt status, set wins over read clear
		if (addr_ph && !hwrite && a == encdiag_pkg::OFS_IRQ_ST && in_map(haddr)) begin
			d.irq_st = ev;
		end else begin
			d.irq_st = q.irq_st | ev;
		end
		d.irq = |(d.irq_st & d.irq_mask);
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ctrl <= encdiag_pkg::CTRL_RST;
			q.res <= encdiag_pkg::RES_RST;
			q.mlen <= encdiag_pkg::MLEN_RST;
			q.irq_mask <= encdiag_pkg::IRQ_MASK_RST;
			q.hreadyout <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign hrdata    = q.hrdata;
	assign hreadyout = q.hreadyout;
	assign hresp     = q.hresp;
	assign pos_out   = q.pos;
	assign pos_valid = q.pos_valid;
	assign ext_diag  = q.ext_diag;
	assign stat_diag = q.stat_diag;
	assign irq       = q.irq;
endmodule // encoder_extended_diagnostics

//--- rtl/ophour_counter.sv
`timescale 1ns/1ps
module ophour_counter #(
	parameter logic [35:0] TICK_CYC = encdiag_pkg::OPH_TICK_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        run,
	output logic [31:0]      count,
	output logic             tick
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [35:0] pre;
		logic [31:0] count;
		logic        tick;
	} oph_t;

	oph_t q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (run) begin
			if (q.pre >= TICK_CYC - 36'h1) begin
				d.pre = 36'h0;
				d.count = q.count + 32'h1;
				d.tick = 1'b1;
			end else begin
				d.pre = q.pre + 36'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign count = q.count;
	assign tick  = q.tick;
endmodule // ophour_counter

//--- shared/encdiag_pkg.sv
// Functional notes
// - Profile version packed revision number then index, 1.40 reads 0140
// - Firmware version packed like profile version
// - 32-bit operating hour counter, one count per 6 minutes
// - Counter reads 24-bit maximum value 00ffffff when the hour function is off
// - Offset to scanned position computed at preset is reported
// - Maker offset to scanned position taken at preset is reported
// - Configured increments per revolution are reported
// - Configured total measuring length in increments is reported
// - Maker-specific diagnostic area carries no content
// - Internal error sets extended-diagnosis and static-diagnosis flags
// - Position data withheld while flags set; master drops device meanwhile
// - No bus acknowledgement clears the error flags
// - Error flagging only active with commissioning diagnosis enabled
package encdiag_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_WARN     = 8'h04;
	localparam logic [7:0] OFS_WARN_SUP = 8'h08;
	localparam logic [7:0] OFS_VERSION  = 8'h0c;
	localparam logic [7:0] OFS_OPHOURS  = 8'h10;
	localparam logic [7:0] OFS_PRESET   = 8'h14;
	localparam logic [7:0] OFS_OFFSET   = 8'h18;
	localparam logic [7:0] OFS_MFR_OFS  = 8'h1c;
	localparam logic [7:0] OFS_RES      = 8'h20;
	localparam logic [7:0] OFS_MLEN     = 8'h24;
	localparam logic [7:0] OFS_DIAG     = 8'h28;
	localparam logic [7:0] OFS_IRQ_ST   = 8'h2c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
	localparam logic [7:0] OFS_MFR_AREA = 8'h34;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_DIAG_EN = 0;
	localparam int CTRL_OPH_EN  = 1;
	localparam int DIAG_EXT     = 0;
	localparam int DIAG_STAT    = 1;
	localparam int EV_ERROR     = 0;
	localparam int EV_WARN      = 1;
	localparam int EV_PRESET    = 2;
	localparam int EV_OPH_TICK  = 3;
	localparam int N_WARN       = 5;
	localparam int N_EV         = 4;

	// ****************************************
	// Values after reset and fixed words
	// ****************************************
	localparam logic [1:0]  CTRL_RST     = 2'h3;
	localparam logic [31:0] RES_RST      = 32'h0000_2000;
	localparam logic [31:0] MLEN_RST     = 32'h0200_0000;
	localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
	localparam logic [15:0] WARN_SUP     = 16'h001f;
	localparam logic [7:0]  PROF_REV_NUM = 8'h01;
	localparam logic [7:0]  PROF_REV_IDX = 8'h40;
	localparam logic [7:0]  FW_REV_NUM   = 8'h01;
	localparam logic [7:0]  FW_REV_IDX   = 8'h00;
	localparam logic [31:0] OPH_MAX      = 32'h00ff_ffff;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint CLK_HZ     = 125_000_000;
	localparam longint OPH_TICK_S = 360;
	localparam logic [35:0] OPH_TICK_CYC = 36'(OPH_TICK_S * CLK_HZ);
endpackage
